// *** hdl/hscp_consts.vh ***
// Purpose: Constants for the host serial command port
// Assumes: sys_clk at 100 MHz, link clock sampled as ordinary input
// Notes:   Times in ns, cycle counts derived from the clock period
// Contract
// - A command carries one or two bytes from host to device, each shifted most significant bit first.
// - Reply bytes go out to the host most significant bit first, least significant bit last.
// - Each command bit is captured on a rising edge of the serial clock.
// - A received command is executed only when chip select rises at the end of the transfer.
// - The port works whether the serial clock idles high or low at either end of the transfer.
// - After switch-on every block except the oscillator and this port sits in powersave until commanded on.
// - Reply data is driven only inside a transaction and released within 1.0 us of chip select rising.
`ifndef HSCP_CONSTS_VH
`define HSCP_CONSTS_VH

`define HSCP_CLK_PERIOD_NS   10
`define HSCP_HIZ_MAX_NS      1000
`define HSCP_HIZ_CYCLES      (`HSCP_HIZ_MAX_NS / `HSCP_CLK_PERIOD_NS)
`define HSCP_BYTE_BITS       8
`define HSCP_MSB             7
`define HSCP_PWR_RESET       8'h00
`define HSCP_CMD_PWR_BIT     7

`endif

// *** hdl/hscp_port.v ***
// Purpose: Device end of the four-wire host serial command port
// Assumes: Pins asynchronous to sys_clk; each serial clock level lasts three sys_clk periods or more
// Notes:   Commands leave on cmd_valid when chip select rises; replies come in on reply_byte
`timescale 1ns/1ps
`include "hscp_consts.vh"
module hscp_port #(
	parameter PWR_W = 8
) (
	input  wire             sys_clk,
	input  wire             rst,
	input  wire             chip_select_low,
	input  wire             serial_clk,
	input  wire             command_data_in,
	output wire             reply_data_out,
	output reg              reply_data_oe,
	output reg              cmd_valid,
	output reg  [7:0]       cmd_addr,
	output reg  [7:0]       cmd_data,
	output reg  [1:0]       cmd_len,
	output reg              reply_req,
	output reg  [7:0]       reply_addr,
	input  wire [7:0]       reply_byte,
	output reg  [PWR_W-1:0] power_on
);
	localparam [1:0]   ST_IDLE    = 2'h0;
	localparam [1:0]   ST_XFER    = 2'h1;
	localparam [1:0]   ST_REL     = 2'h2;
	localparam integer HIZ_LAST_I = `HSCP_HIZ_CYCLES - 1;
	localparam [9:0]   HIZ_LAST   = HIZ_LAST_I[9:0];
	localparam integer MSB_I      = `HSCP_MSB;
	localparam [2:0]   LAST_BIT   = MSB_I[2:0];

	wire       cs_n_s;
	wire       sck_s;
	wire       din_s;
	wire       sck_rise;
	wire       sck_fall;
	wire       cs_fall;
	wire       cs_rise;
	wire       start_xfer;
	wire       end_xfer;
	wire       take_bit;
	wire       byte_done;
	wire       first_done;
	wire       shift_out;
	wire       pwr_cmd;
	wire [7:0] rx_byte;
	reg        sck_d_r;
	reg        cs_d_r;
	reg  [1:0] state_r;
	reg  [1:0] state_nxt;
	reg  [2:0] bit_cnt_r;
	reg  [1:0] byte_cnt_r;
	reg  [7:0] shift_r;
	reg  [7:0] first_r;
	reg  [7:0] second_r;
	reg  [7:0] tx_r;
	reg        out_r;
	reg        started_r;
	reg  [9:0] hiz_cnt_r;

	// Select resets to its idle level; a low start would look like a select edge
	hscp_sync #(
		.RST_VAL (1'b1)
	) u_cs (
		.clk (sys_clk),
		.rst (rst),
		.d   (chip_select_low),
		.q   (cs_n_s)
	);

	// Serial clock may idle at either level; a false edge here is ignored while deselected
	hscp_sync #(
		.RST_VAL (1'b0)
	) u_sck (
		.clk (sys_clk),
		.rst (rst),
		.d   (serial_clk),
		.q   (sck_s)
	);

	hscp_sync #(
		.RST_VAL (1'b0)
	) u_din (
		.clk (sys_clk),
		.rst (rst),
		.d   (command_data_in),
		.q   (din_s)
	);

	always @(posedge sys_clk) begin
		if (rst) begin
			sck_d_r <= 1'b0;
			cs_d_r  <= 1'b1;
		end else begin
			sck_d_r <= sck_s;
			cs_d_r  <= cs_n_s;
		end
	end

	assign sck_rise   = sck_s & ~sck_d_r;
	assign sck_fall   = ~sck_s & sck_d_r;
	assign cs_fall    = ~cs_n_s & cs_d_r;
	assign cs_rise    = cs_n_s & ~cs_d_r;
	assign start_xfer = cs_fall & (state_r != ST_XFER);
	assign end_xfer   = cs_rise & (state_r == ST_XFER);
	// Bits past the second byte are ignored
	assign take_bit   = sck_rise & ~cs_rise & (state_r == ST_XFER) & (byte_cnt_r != 2'h2);
	assign byte_done  = take_bit & (bit_cnt_r == LAST_BIT);
	assign first_done = byte_done & (byte_cnt_r == 2'h0);
	assign rx_byte    = {shift_r[6:0], din_s};
	// Reply bits change on falling edges so the host sees them settled at the rise
	assign shift_out  = sck_fall & ~cs_rise & started_r & (state_r == ST_XFER);
	assign pwr_cmd    = first_r[`HSCP_CMD_PWR_BIT] & (byte_cnt_r == 2'h2);

	assign reply_data_out = out_r;

	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: begin
			if (start_xfer)
				state_nxt = ST_XFER;
		end
		ST_XFER: begin
			if (cs_rise)
				state_nxt = ST_REL;
		end
		ST_REL: begin
			// A host keeping the minimum gap selects again before the count ends
			if (start_xfer)
				state_nxt = ST_XFER;
			else if (hiz_cnt_r >= HIZ_LAST)
				state_nxt = ST_IDLE;
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	always @(posedge sys_clk) begin
		if (rst)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always @(posedge sys_clk) begin
		if (rst)
			hiz_cnt_r <= 10'h000;
		else if (state_r == ST_REL)
			hiz_cnt_r <= hiz_cnt_r + 10'h001;
		else
			hiz_cnt_r <= 10'h000;
	end

	// Only whole bytes count; a partial byte is dropped
	always @(posedge sys_clk) begin
		if (rst) begin
			bit_cnt_r  <= 3'h0;
			byte_cnt_r <= 2'h0;
			shift_r    <= 8'h00;
			first_r    <= 8'h00;
			second_r   <= 8'h00;
		end else if (start_xfer) begin
			bit_cnt_r  <= 3'h0;
			byte_cnt_r <= 2'h0;
		end else if (take_bit) begin
			shift_r   <= rx_byte;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (byte_done) begin
				byte_cnt_r <= byte_cnt_r + 2'h1;
				if (byte_cnt_r == 2'h0)
					first_r <= rx_byte;
				else
					second_r <= rx_byte;
			end
		end
	end

	// Falls before the first rise belong to the clock's idle level, not to data
	always @(posedge sys_clk) begin
		if (rst)
			started_r <= 1'b0;
		else if (start_xfer)
			started_r <= 1'b0;
		else if (take_bit)
			started_r <= 1'b1;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			reply_req  <= 1'b0;
			reply_addr <= 8'h00;
		end else begin
			reply_req <= first_done;
			if (first_done)
				reply_addr <= rx_byte;
		end
	end

	// A fall in the load cycle would be lost; levels of three cycles keep it apart
	always @(posedge sys_clk) begin
		if (rst) begin
			tx_r  <= 8'h00;
			out_r <= 1'b0;
		end else if (start_xfer) begin
			tx_r <= 8'h00;
		end else if (reply_req) begin
			tx_r <= reply_byte;
		end else if (shift_out) begin
			out_r <= tx_r[`HSCP_MSB];
			tx_r  <= {tx_r[6:0], 1'b0};
		end
	end

	always @(posedge sys_clk) begin
		if (rst)
			reply_data_oe <= 1'b0;
		else if (state_r != ST_XFER || cs_rise)
			reply_data_oe <= 1'b0;
		else if (shift_out)
			reply_data_oe <= 1'b1;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			cmd_valid <= 1'b0;
			cmd_addr  <= 8'h00;
			cmd_data  <= 8'h00;
			cmd_len   <= 2'h0;
		end else begin
			cmd_valid <= end_xfer & (byte_cnt_r != 2'h0);
			if (end_xfer && byte_cnt_r != 2'h0) begin
				cmd_addr <= first_r;
				cmd_data <= second_r;
				cmd_len  <= byte_cnt_r;
			end
		end
	end

	// Only the low PWR_W bits of the data byte are used, so PWR_W stays at 8 or below
	always @(posedge sys_clk) begin
		if (rst)
			power_on <= {PWR_W{1'b0}};
		else if (end_xfer && pwr_cmd)
			power_on <= second_r[PWR_W-1:0];
	end
endmodule // hscp_port

// *** hdl/hscp_sync.v ***
// Purpose: Two-stage synchroniser for one level
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second stage; RST_VAL should match the pin's idle level
`timescale 1ns/1ps
module hscp_sync #(
	parameter [0:0] RST_VAL = 1'b0
) (
	input  wire clk,
	input  wire rst,
	input  wire d,
	output reg  q
);
	reg meta_r;

	always @(posedge clk) begin
		if (rst) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // hscp_sync

// *** verification/hscp_host.sv ***
// Purpose: Host model of the serial link
// Assumes: 80 ns link clock period
// Notes: Released data line shows the inverse
`timescale 1ns/1ps
module hscp_host (
	input  wire sys_clk,
	input  wire rpl,
	output reg  cs_low = 1'b1,
	output reg  sclk = 1'b0,
	output reg  dout = 1'b0
);
	task xfer(input [15:0] w, input [4:0] n, input pol, output [7:0] rep);
		integer i;
		begin
			sclk = pol;
			@(negedge sys_clk);
			cs_low = 1'b0;
			repeat (6) @(negedge sys_clk);
			for (i = 0; i < n; i = i + 1) begin
				sclk = 1'b0;
				dout = w[15 - i];
				repeat (4) @(negedge sys_clk);
				if (i > 7) rep[15 - i] = rpl;
				sclk = 1'b1;
				repeat (4) @(negedge sys_clk);
			end
			sclk = pol;
			repeat (6) @(negedge sys_clk);
			cs_low = 1'b1;
			dout = ~dout;
			repeat (100) @(negedge sys_clk);
		end
	endtask
endmodule // hscp_host

// *** verification/hscp_port_asserts.sv ***
// Purpose: Port checks
// Assumes: Top ports only
// Notes: None
`timescale 1ns/1ps
`include "hscp_consts.vh"
module hscp_port_asserts #(
	parameter PWR_W = 8
) (
	input wire             sys_clk,
	input wire             rst,
	input wire             chip_select_low,
	input wire             reply_data_oe,
	input wire             cmd_valid,
	input wire [7:0]       cmd_addr,
	input wire [1:0]       cmd_len,
	input wire             reply_req,
	input wire [PWR_W-1:0] power_on
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	oe_release_a: assert property ($rose(chip_select_low) |-> ##[1:100] !reply_data_oe) else $error("oe held");
	oe_idle_a: assert property (chip_select_low [*8] |-> !reply_data_oe) else $error("oe idle");
	exec_end_a: assert property (cmd_valid |-> chip_select_low && $past(chip_select_low, 3)) else $error("early");
	valid_pulse_a: assert property (cmd_valid |=> !cmd_valid) else $error("valid");
	len_range_a: assert property (cmd_valid |-> cmd_len == 2'h1 || cmd_len == 2'h2) else $error("len");
	req_pulse_a: assert property (reply_req |=> !reply_req) else $error("req");
	req_framed_a: assert property (reply_req |-> !chip_select_low) else $error("req cs");
	pwr_cause_a: assert property (!$stable(power_on) |-> cmd_valid && cmd_len == 2'h2 && cmd_addr[`HSCP_CMD_PWR_BIT]) else $error("pwr");
endmodule // hscp_port_asserts
bind hscp_port hscp_port_asserts #(
	.PWR_W (PWR_W)
) u_chk (
	.sys_clk         (sys_clk),
	.rst             (rst),
	.chip_select_low (chip_select_low),
	.reply_data_oe   (reply_data_oe),
	.cmd_valid       (cmd_valid),
	.cmd_addr        (cmd_addr),
	.cmd_len         (cmd_len),
	.reply_req       (reply_req),
	.power_on        (power_on)
);

// *** verification/test_hscp_port.sv ***
// Purpose: Bench for the serial port
// Assumes: Host model drives pins
// Notes: Reply is command xor 5a
`timescale 1ns/1ps
module test_hscp_port;
	reg        sys_clk = 1'b0;
	reg        rst = 1'b1;
	reg  [7:0] nv = 8'h00;
	reg  [7:0] rep;
	wire       cs, sk, din, dq, oe, cv, rq;
	wire [7:0] ad, da, ra, pw;
	wire [1:0] ln;
	integer    num_errors = 0;
	integer    cmp_count = 0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (cv === 1'b1) nv <= nv + 8'h01;
	// No pull on the reply line: a released line reads as the inverse of its last value
	hscp_host u_host (.sys_clk(sys_clk), .rpl(oe ? dq : ~dq), .cs_low(cs), .sclk(sk), .dout(din));
	hscp_port u_dut (.sys_clk(sys_clk), .rst(rst), .chip_select_low(cs), .serial_clk(sk), .command_data_in(din),
		.reply_data_out(dq), .reply_data_oe(oe), .cmd_valid(cv), .cmd_addr(ad), .cmd_data(da), .cmd_len(ln),
		.reply_req(rq), .reply_addr(ra), .reply_byte(ra ^ 8'h5a), .power_on(pw));
	task check(input string nm, input [7:0] s, input [7:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (s !== e) begin
				num_errors = num_errors + 1;
				$display("unexpected %s: expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task end_of_test;
		begin
			if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
			else $display("Simulation failed");
			$finish;
		end
	endtask
	task t_power;
		begin
			check("pwr0", pw, 8'h00);
			u_host.xfer(16'h83a5, 5'd16, 1'b0, rep);
			check("reply", rep, 8'hd9);
			check("addr", ad, 8'h83);
			check("data", da, 8'ha5);
			check("len", {6'h00, ln}, 8'h02);
			check("pwr", pw, 8'ha5);
			check("execs", nv, 8'h01);
		end
	endtask
	task t_short;
		begin
			u_host.xfer(16'h1200, 5'd8, 1'b1, rep);
			check("addr1", ad, 8'h12);
			check("len1", {6'h00, ln}, 8'h01);
			check("pwr1", pw, 8'ha5);
		end
	endtask
	task t_partial;
		begin
			u_host.xfer(16'h4c30, 5'd12, 1'b1, rep);
			check("addr2", ad, 8'h4c);
			check("len2", {6'h00, ln}, 8'h01);
			check("reply2", {4'h0, rep[7:4]}, 8'h01);
			u_host.xfer(16'hf000, 5'd4, 1'b0, rep);
			check("execs2", nv, 8'h03);
			check("addr3", ad, 8'h4c);
		end
	endtask
	initial begin
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		t_power;
		t_short;
		t_partial;
		end_of_test;
	end
	initial begin
		repeat (2000) @(posedge sys_clk);
		num_errors = num_errors + 1;
		end_of_test;
	end
endmodule // test_hscp_port
